/* File: gpe_params.svh */
// Purpose: Register offsets, field positions and reset values of the pin block
// Assumes: 32-bit register data, byte addresses on word boundaries
// Notes: Only pins 15, 11 and 7 to 4 of the pin group are built
`ifndef GPE_PARAMS_SVH
`define GPE_PARAMS_SVH

`define GPE_ADDR_W 8
`define GPE_OFS_DIR 8'h00
`define GPE_OFS_DOUT 8'h04
`define GPE_OFS_DIN 8'h08
`define GPE_OFS_IER 8'h0c
`define GPE_OFS_POL 8'h10
`define GPE_OFS_PCISEL 8'h14
`define GPE_OFS_STATUS 8'h18
`define GPE_OFS_MASK 8'h1c

`define GPE_PIN_MASK 16'h88f0
`define GPE_EXT_LSB 4
`define GPE_PIN_RST 15
`define GPE_PIN_REQ 11
`define GPE_SEL_RST_BIT 0
`define GPE_SEL_REQ_BIT 1
`define GPE_ST_NMI_BIT 0

`define GPE_RST_DIR 16'h0000
`define GPE_RST_DOUT 16'h0000
`define GPE_RST_IER 4'h0
`define GPE_RST_POL 4'h0
`define GPE_RST_STATUS 8'h00
`define GPE_RST_MASK 8'h00

`endif

/* File: gpe_pkg.sv */
// Purpose: Types shared by the pin block
// Assumes: Nothing beyond the parameter header
// Notes: Events carry the one-cycle hits seen in the clock domain
package gpe_pkg;

	typedef struct packed {
		logic [3:0] ext;
		logic [2:0] spare;
		logic nmi;
	} gpe_evt_t;

	typedef struct packed {
		logic sel_rst;
		logic sel_req;
	} gpe_pci_t;

endpackage : gpe_pkg

/* File: gpe_pin_sync.sv */
// Purpose: Two-flop synchroniser with edge detection per pin
// Assumes: Inputs are asynchronous board pins
// Notes: Edges are seen between the second and third flop only
`timescale 1ns/10ps
module gpe_pin_sync #(
	parameter int W = 7,
	// Reset value of each flop: the pin's idle level, so no false edge follows reset
	parameter logic [W-1:0] IDLE = '0
) (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Pins
	input wire logic [W-1:0] pin_i,
	// Synchronised level and edges
	output logic [W-1:0] lvl_o,
	output logic [W-1:0] rise_o,
	output logic [W-1:0] fall_o
);

	logic [W-1:0] s1_r;
	logic [W-1:0] s2_r;
	logic [W-1:0] s3_r;
	logic [W-1:0] s1_nxt;
	logic [W-1:0] s2_nxt;
	logic [W-1:0] s3_nxt;

	always_comb begin
		s1_nxt = pin_i;
		s2_nxt = s1_r;
		s3_nxt = s2_r;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			s1_r <= IDLE;
			s2_r <= IDLE;
			s3_r <= IDLE;
		end else begin
			s1_r <= s1_nxt;
			s2_r <= s2_nxt;
			s3_r <= s3_nxt;
		end
	end

	genvar g;
	for (g = 0; g < W; g++) begin : g_bit
		assign lvl_o[g] = s2_r[g];
		assign rise_o[g] = s2_r[g] & ~s3_r[g];
		assign fall_o[g] = ~s2_r[g] & s3_r[g];
	end

endmodule : gpe_pin_sync

/* File: gpe_pins.sv */
// Purpose: General-purpose pins 15, 11, 7 to 4 with external and nonmaskable interrupts
// Assumes: Board pins are asynchronous; core strobes and acks are on clk_i
// Notes: Register read data appear one cycle after the read strobe
`timescale 1ns/10ps
`include "gpe_params.svh"

// How it works
// - The nonmaskable interrupt is raised only by a rising edge on its input, never by a level.
// - After reset pins 7 to 4 are inputs with their drivers off.
// - Pins 7 to 4 are three-state GPIO or input-only interrupt sources and are never driven in interrupt use.
// - A pin among 7 to 4 is an edge interrupt while its enable bit in positions 7 to 4 is set.
// - Four polarity bits, 3 to 0, pick the edge of each interrupt pin on its own.
// - Pin 15 is GPIO or, with its PCI select set, the PCI reset input.
// - Pin 11 is GPIO or, with its PCI select set, the three-state PCI bus request output.
module gpe_pins (
	// Clock and reset
	input wire logic clk_i,
	input wire logic rst_i,
	// Register port
	input wire logic [`GPE_ADDR_W-1:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	// Pin group
	input wire logic [15:0] gp_pin_group_i,
	output logic [15:0] gp_pin_group_o,
	output logic [15:0] gp_pin_group_oe_o,
	// Nonmaskable interrupt pin
	input wire logic nmi_i,
	// PCI side
	input wire logic pci_bus_request_out_i,
	input wire logic pci_bus_request_oe_i,
	output logic pci_reset_in_o,
	// CPU interrupt logic
	input wire logic nmi_ack_i,
	input wire logic [3:0] ext_irq_ack_i,
	output logic nmi_pend_o,
	output logic [3:0] ext_irq_pend_o,
	output logic irq_o
);

	// Synchronised pins: [6] nmi, [5] pin 15, [4] pin 11, [3:0] pins 7 to 4
	logic [6:0] sy_lvl;
	logic [6:0] sy_rise;
	logic [6:0] sy_fall;

	gpe_pin_sync #(
		// Pins 7 to 4 idle high on their pull-ups, the rest idle low
		.W(7),
		.IDLE(7'h0f)
	) u_sync (
		.clk_i(clk_i),
		.rst_i(rst_i),
		.pin_i({nmi_i, gp_pin_group_i[`GPE_PIN_RST], gp_pin_group_i[`GPE_PIN_REQ],
			gp_pin_group_i[`GPE_EXT_LSB+3:`GPE_EXT_LSB]}),
		.lvl_o(sy_lvl),
		.rise_o(sy_rise),
		.fall_o(sy_fall)
	);

	logic nmi_rise;
	logic [3:0] lvl_ext;
	logic [15:0] din_w;
	assign nmi_rise = sy_rise[6];
	assign lvl_ext = sy_lvl[3:0];

	always_comb begin
		din_w = 16'h0000;
		din_w[`GPE_PIN_RST] = sy_lvl[5];
		din_w[`GPE_PIN_REQ] = sy_lvl[4];
		din_w[`GPE_EXT_LSB+3:`GPE_EXT_LSB] = sy_lvl[3:0];
	end

	// Configuration registers
	logic [15:0] dir_r;
	logic [15:0] dir_nxt;
	logic [15:0] dout_r;
	logic [15:0] dout_nxt;
	logic [3:0] ier_r;
	logic [3:0] ier_nxt;
	logic [3:0] pol_r;
	logic [3:0] pol_nxt;
	gpe_pkg::gpe_pci_t pci_r;
	gpe_pkg::gpe_pci_t pci_nxt;
	logic [7:0] mask_r;
	logic [7:0] mask_nxt;
	logic sel_rst_r;
	logic sel_req_r;
	assign sel_rst_r = pci_r.sel_rst;
	assign sel_req_r = pci_r.sel_req;

	always_comb begin
		dir_nxt = dir_r;
		dout_nxt = dout_r;
		ier_nxt = ier_r;
		pol_nxt = pol_r;
		pci_nxt = pci_r;
		mask_nxt = mask_r;
		if (wr_i) begin
			unique case (addr_i)
				`GPE_OFS_DIR: dir_nxt = wdata_i[15:0] & `GPE_PIN_MASK;
				`GPE_OFS_DOUT: dout_nxt = wdata_i[15:0] & `GPE_PIN_MASK;
				`GPE_OFS_IER: ier_nxt = wdata_i[`GPE_EXT_LSB+3:`GPE_EXT_LSB];
				`GPE_OFS_POL: pol_nxt = wdata_i[3:0];
				`GPE_OFS_PCISEL: begin
					pci_nxt.sel_rst = wdata_i[`GPE_SEL_RST_BIT];
					pci_nxt.sel_req = wdata_i[`GPE_SEL_REQ_BIT];
				end
				`GPE_OFS_MASK: mask_nxt = wdata_i[7:0] & 8'hf1;
				default: begin
				end
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dir_r <= `GPE_RST_DIR;
			dout_r <= `GPE_RST_DOUT;
			ier_r <= `GPE_RST_IER;
			pol_r <= `GPE_RST_POL;
			pci_r <= '0;
			mask_r <= `GPE_RST_MASK;
		end else begin
			dir_r <= dir_nxt;
			dout_r <= dout_nxt;
			ier_r <= ier_nxt;
			pol_r <= pol_nxt;
			pci_r <= pci_nxt;
			mask_r <= mask_nxt;
		end
	end

	// Edge selection and pending flags
	gpe_pkg::gpe_evt_t evt;
	logic [3:0] ext_hit;
	logic [3:0] ext_pend_r;
	logic [3:0] ext_pend_nxt;
	logic nmi_pend_r;
	logic nmi_pend_nxt;
	logic [7:0] status_r;
	logic [7:0] status_nxt;
	logic rd_status;

	assign ext_hit = ier_r & ((sy_rise[3:0] & ~pol_r) | (sy_fall[3:0] & pol_r));
	assign rd_status = rd_i && (addr_i == `GPE_OFS_STATUS);

	always_comb begin
		evt = '0;
		evt.nmi = nmi_rise;
		evt.ext = ext_hit;
		// Set wins over clear on every flag
		ext_pend_nxt = (ext_pend_r & ~ext_irq_ack_i) | ext_hit;
		nmi_pend_nxt = (nmi_pend_r & ~nmi_ack_i) | nmi_rise;
		status_nxt = (rd_status ? 8'h00 : status_r) | evt;
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ext_pend_r <= 4'h0;
			nmi_pend_r <= 1'b0;
			status_r <= `GPE_RST_STATUS;
		end else begin
			ext_pend_r <= ext_pend_nxt;
			nmi_pend_r <= nmi_pend_nxt;
			status_r <= status_nxt;
		end
	end

	// Pin drivers and outputs
	logic [15:0] gp_o_r;
	logic [15:0] gp_o_nxt;
	logic [15:0] gp_oe_r;
	logic [15:0] gp_oe_nxt;
	logic pci_rst_r;
	logic pci_rst_nxt;
	logic irq_r;
	logic irq_nxt;

	always_comb begin
		gp_o_nxt = dout_r;
		gp_oe_nxt = dir_r;
		// Interrupt pins are input only
		gp_oe_nxt[`GPE_EXT_LSB+3:`GPE_EXT_LSB] = dir_r[`GPE_EXT_LSB+3:`GPE_EXT_LSB] & ~ier_r;
		if (sel_rst_r) begin
			gp_oe_nxt[`GPE_PIN_RST] = 1'b0;
		end
		if (sel_req_r) begin
			gp_o_nxt[`GPE_PIN_REQ] = pci_bus_request_out_i;
			gp_oe_nxt[`GPE_PIN_REQ] = pci_bus_request_oe_i;
		end
		pci_rst_nxt = sel_rst_r & sy_lvl[5];
		irq_nxt = |(status_nxt & mask_r);
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			gp_o_r <= 16'h0000;
			gp_oe_r <= 16'h0000;
			pci_rst_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			gp_o_r <= gp_o_nxt;
			gp_oe_r <= gp_oe_nxt;
			pci_rst_r <= pci_rst_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Register read port
	logic [31:0] rdata_r;
	logic [31:0] rdata_nxt;

	always_comb begin
		rdata_nxt = 32'h00000000;
		if (rd_i) begin
			unique case (addr_i)
				`GPE_OFS_DIR: rdata_nxt[15:0] = dir_r;
				`GPE_OFS_DOUT: rdata_nxt[15:0] = dout_r;
				`GPE_OFS_DIN: rdata_nxt[15:0] = din_w;
				`GPE_OFS_IER: rdata_nxt[`GPE_EXT_LSB+3:`GPE_EXT_LSB] = ier_r;
				`GPE_OFS_POL: rdata_nxt[3:0] = pol_r;
				`GPE_OFS_PCISEL: rdata_nxt[1:0] = {sel_req_r, sel_rst_r};
				`GPE_OFS_STATUS: rdata_nxt[7:0] = status_r;
				`GPE_OFS_MASK: rdata_nxt[7:0] = mask_r;
				default: rdata_nxt = 32'h00000000;
			endcase
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			rdata_r <= 32'h00000000;
		end else begin
			rdata_r <= rdata_nxt;
		end
	end

	assign rdata_o = rdata_r;
	assign gp_pin_group_o = gp_o_r;
	assign gp_pin_group_oe_o = gp_oe_r;
	assign pci_reset_in_o = pci_rst_r;
	assign nmi_pend_o = nmi_pend_r;
	assign ext_irq_pend_o = ext_pend_r;
	assign irq_o = irq_r;

	// Checks
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);

	logic [3:0] hold_w;
	assign hold_w = ext_pend_r & ~ext_irq_ack_i;

	sequence s_nmi_edge;
		!sy_lvl[6] ##1 sy_lvl[6];
	endsequence

	a_nmi_edge_pend: assert property (s_nmi_edge |=> nmi_pend_o)
		else $error("rising nmi edge not made pending");

	a_nmi_no_level: assert property (nmi_pend_r && !$past(nmi_pend_r) |-> $past(nmi_rise))
		else $error("nmi pending without a rising edge");

	a_reset_no_drive: assert property ($fell(rst_i) |-> gp_pin_group_oe_o[7:4] == 4'h0)
		else $error("pins 7 to 4 driven after reset");

	a_irq_no_drive: assert property ((gp_pin_group_oe_o[7:4] & $past(ier_r)) == 4'h0)
		else $error("interrupt pin is driven");

	a_ext_edge_pend: assert property (|ext_hit |=> (ext_irq_pend_o & $past(ext_hit)) == $past(ext_hit))
		else $error("external edge not made pending");

	a_ext_off_quiet: assert property (((ext_irq_pend_o & ~$past(ext_irq_pend_o)) & ~$past(ier_r)) == 4'h0)
		else $error("disabled pin raised pending flag");

	a_pol_edge_dir: assert property (|ext_hit |-> ((lvl_ext ^ pol_r) & ext_hit) == ext_hit)
		else $error("edge taken against polarity");

	a_pend_hold_ack: assert property (1'b1 |=> (ext_irq_pend_o & $past(hold_w)) == $past(hold_w))
		else $error("pending flag lost before ack");

	a_pci_rst_hiz: assert property (sel_rst_r |=> !gp_pin_group_oe_o[15])
		else $error("pci reset pin is driven");

	a_pci_req_out: assert property (sel_req_r && pci_bus_request_oe_i |=> gp_pin_group_oe_o[11]
		&& gp_pin_group_o[11] == $past(pci_bus_request_out_i))
		else $error("pci request not passed to pin 11");

	a_pci_req_hiz: assert property (sel_req_r && !pci_bus_request_oe_i |=> !gp_pin_group_oe_o[11])
		else $error("pin 11 driven while pci request is released");

	a_pci_rst_off: assert property (!sel_rst_r |=> !pci_reset_in_o)
		else $error("pci reset shown without its select");

	a_nmi_ack_hold: assert property (nmi_pend_o && !nmi_ack_i |=> nmi_pend_o)
		else $error("nmi pending lost before ack");

	a_nmi_ack_clr: assert property (nmi_pend_o && nmi_ack_i && !nmi_rise |=> !nmi_pend_o)
		else $error("nmi pending kept after ack");

	a_ext_ack_clr: assert property (1'b1 |=> (ext_irq_pend_o & $past(ext_irq_ack_i & ~ext_hit)) == 4'h0)
		else $error("external pending kept after ack");

	a_gp_out_path: assert property (!sel_req_r |=> gp_pin_group_o == $past(dout_r))
		else $error("pin output differs from output register");

	a_oe_needs_dir: assert property (1'b1 |=> (gp_pin_group_oe_o[7:4] & ~$past(dir_r[7:4])) == 4'h0)
		else $error("pin driven without its direction bit");

	a_unbuilt_no_drive: assert property ((gp_pin_group_oe_o & ~`GPE_PIN_MASK) == 16'h0000)
		else $error("unbuilt pin is driven");

	a_status_set_wins: assert property (evt.nmi |=> status_r[0])
		else $error("nmi status not set");

	a_status_rd_clr: assert property (rd_status |=> status_r == $past(evt))
		else $error("status not cleared by its read");

	a_status_no_spare: assert property (status_r[3:1] == 3'h0)
		else $error("spare status bits set");

	a_irq_from_status: assert property (1'b1 |=> irq_o == |(status_r & $past(mask_r)))
		else $error("interrupt output differs from masked status");

	a_mask_gates_irq: assert property (mask_r == 8'h00 |=> !irq_o)
		else $error("interrupt raised with all sources masked");

	a_rdata_one_cycle: assert property (!rd_i |=> rdata_o == 32'h00000000)
		else $error("read data stand without a read");

	sequence s_pin4_fall;
		sy_lvl[0] ##1 !sy_lvl[0] && ier_r[0] && pol_r[0];
	endsequence

	sequence s_pin5_rise;
		!sy_lvl[1] ##1 sy_lvl[1] && ier_r[1] && !pol_r[1];
	endsequence

	a_fall_pend_pin4: assert property (s_pin4_fall |=> ext_irq_pend_o[0])
		else $error("falling edge on pin 4 not made pending");

	a_rise_pend_pin5: assert property (s_pin5_rise |=> ext_irq_pend_o[1])
		else $error("rising edge on pin 5 not made pending");

endmodule : gpe_pins

/* File: gpe_board.sv */
// Purpose: Board model driving the pin group and the nonmaskable interrupt pin
// Assumes: Pins with pull-ups settle high when nobody drives them
// Notes: The device wins over the board when both drive a pin
`timescale 1ns/10ps
module gpe_board (
	// Bench control
	input wire logic [15:0] drv_i,
	input wire logic [15:0] den_i,
	input wire logic nmi_drv_i,
	// Device side
	input wire logic [15:0] dev_out_i,
	input wire logic [15:0] dev_oe_i,
	// Resolved pins
	output logic [15:0] pin_o,
	output logic nmi_o
);
	always_comb begin
		for (int k = 0; k < 16; k++) begin
			pin_o[k] = dev_oe_i[k] ? dev_out_i[k] : (den_i[k] ? drv_i[k] : 1'b1);
		end
	end
	assign nmi_o = nmi_drv_i;
endmodule : gpe_board

/* File: gpe_pins_bench.sv */
// Purpose: Self-checking bench of the pin block
// Assumes: Register reads answer one cycle after the strobe
// Notes: Pin edges are given five cycles to reach the pending outputs
`timescale 1ns/10ps
`include "gpe_params.svh"
module gpe_pins_bench;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic [7:0] addr_i = 8'h00;
	logic [31:0] wdata_i = 32'h0;
	logic wr_i = 1'b0;
	logic rd_i = 1'b0;
	logic [31:0] rdata_o, rv;
	logic [15:0] pin, gp_o, gp_oe;
	logic [15:0] drv = 16'h0;
	logic [15:0] den = 16'h0;
	logic nmi_drv = 1'b0;
	logic req_out = 1'b0;
	logic req_oe = 1'b0;
	logic nmi_ack = 1'b0;
	logic [3:0] ext_ack = 4'h0;
	logic [3:0] ext_pend;
	logic nmi, pci_reset_in, nmi_pend, irq;
	int err_total = 0;
	int n_tests = 0;
	always #5 clk_i = ~clk_i;
	gpe_pins gpe_pins_i (.clk_i(clk_i), .rst_i(rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
		.rd_i(rd_i), .rdata_o(rdata_o), .gp_pin_group_i(pin), .gp_pin_group_o(gp_o),
		.gp_pin_group_oe_o(gp_oe), .nmi_i(nmi), .pci_bus_request_out_i(req_out),
		.pci_bus_request_oe_i(req_oe), .pci_reset_in_o(pci_reset_in), .nmi_ack_i(nmi_ack),
		.ext_irq_ack_i(ext_ack), .nmi_pend_o(nmi_pend), .ext_irq_pend_o(ext_pend), .irq_o(irq));
	gpe_board gpe_board_i (.drv_i(drv), .den_i(den), .nmi_drv_i(nmi_drv), .dev_out_i(gp_o),
		.dev_oe_i(gp_oe), .pin_o(pin), .nmi_o(nmi));
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			err_total++;
			$display("BAD %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
		#1;
	endtask : cyc
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		wr_i <= 1'b1;
		addr_i <= a;
		wdata_i <= d;
		@(posedge clk_i);
		wr_i <= 1'b0;
	endtask : wr
	task automatic rd(input logic [7:0] a);
		@(posedge clk_i);
		rd_i <= 1'b1;
		addr_i <= a;
		@(posedge clk_i);
		rd_i <= 1'b0;
		#1 rv = rdata_o;
	endtask : rd
	task automatic ack(input logic n, input logic [3:0] e);
		@(posedge clk_i);
		nmi_ack <= n;
		ext_ack <= e;
		@(posedge clk_i);
		nmi_ack <= 1'b0;
		ext_ack <= 4'h0;
	endtask : ack
	task automatic t_reset;
		chk(gp_oe, 32'h0);
		rd(`GPE_OFS_DIR);
		chk(rv, 32'h0);
		rd(`GPE_OFS_IER);
		chk(rv, 32'h0);
	endtask : t_reset
	task automatic t_nmi;
		wr(`GPE_OFS_MASK, 32'h1);
		nmi_drv <= 1'b1;
		cyc(5);
		chk(nmi_pend, 32'h1);
		chk(irq, 32'h1);
		rd(`GPE_OFS_STATUS);
		chk(rv, 32'h1);
		cyc(2);
		chk(irq, 32'h0);
		chk(nmi_pend, 32'h1);
		ack(1'b1, 4'h0);
		cyc(8);
		chk(nmi_pend, 32'h0);
		@(posedge clk_i);
		nmi_drv <= 1'b0;
		cyc(5);
		chk(nmi_pend, 32'h0);
		rd(`GPE_OFS_STATUS);
		chk(rv, 32'h0);
	endtask : t_nmi
	task automatic t_ext;
		@(posedge clk_i);
		den <= 16'h00f0;
		wr(`GPE_OFS_DIR, 32'hf0);
		wr(`GPE_OFS_POL, 32'h1);
		wr(`GPE_OFS_IER, 32'hf0);
		wr(`GPE_OFS_MASK, 32'hf0);
		cyc(2);
		chk(gp_oe, 32'h0);
		@(posedge clk_i);
		drv <= 16'h0030;
		cyc(5);
		chk(ext_pend, 32'h2);
		chk(irq, 32'h1);
		rd(`GPE_OFS_STATUS);
		chk(rv, 32'h20);
		@(posedge clk_i);
		drv <= 16'h0000;
		cyc(5);
		chk(ext_pend, 32'h3);
		ack(1'b0, 4'hf);
		cyc(2);
		chk(ext_pend, 32'h0);
		wr(`GPE_OFS_IER, 32'h0);
		cyc(2);
		chk(gp_oe, 32'hf0);
		wr(`GPE_OFS_DIR, 32'h0);
		rd(`GPE_OFS_STATUS);
		chk(rv, 32'h10);
		@(posedge clk_i);
		drv <= 16'h0040;
		cyc(5);
		chk(ext_pend, 32'h0);
		rd(`GPE_OFS_STATUS);
		chk(rv, 32'h0);
	endtask : t_ext
	task automatic t_gpio;
		wr(`GPE_OFS_DIR, 32'h88f0);
		wr(`GPE_OFS_DOUT, 32'h0050);
		cyc(2);
		chk(gp_o, 32'h0050);
		chk(gp_oe, 32'h88f0);
		wr(`GPE_OFS_DIR, 32'h0);
		den <= 16'h8800;
		drv <= 16'h0800;
		cyc(4);
		rd(`GPE_OFS_DIN);
		chk(rv & 32'h88f0, 32'h08f0);
		rd(8'h20);
		chk(rv, 32'h0);
	endtask : t_gpio
	task automatic t_pci;
		wr(`GPE_OFS_DIR, 32'h8800);
		wr(`GPE_OFS_PCISEL, 32'h3);
		req_out <= 1'b1;
		req_oe <= 1'b1;
		drv <= 16'h8000;
		cyc(4);
		chk(gp_oe & 16'h8800, 32'h0800);
		chk(gp_o[11], 32'h1);
		chk(pci_reset_in, 32'h1);
		@(posedge clk_i);
		drv <= 16'h0000;
		req_oe <= 1'b0;
		cyc(4);
		chk(pci_reset_in, 32'h0);
		chk(gp_oe[11], 32'h0);
		wr(`GPE_OFS_PCISEL, 32'h0);
		cyc(2);
		chk(gp_oe & 16'h8800, 32'h8800);
	endtask : t_pci
	task automatic complete_run;
		$display("errors %0d checks %0d", err_total, n_tests);
		if (err_total == 0 && n_tests > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : complete_run
	initial begin
		repeat (2) @(posedge clk_i);
		rst_i <= 1'b0;
		cyc(1);
		t_reset;
		t_nmi;
		t_ext;
		t_gpio;
		t_pci;
		complete_run;
	end
	initial begin
		#100000;
		err_total++;
		complete_run;
	end
endmodule : gpe_pins_bench
